//--- shared/spm_defines.vh
// Constants for the flash power-mode and signature logic.
// Assumes inclusion by the rtl files; all timing counted in mclk cycles.
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH
// Opcode defaults
`define SPM_OP_DEEP_SLEEP   8'hB9
`define SPM_OP_WAKE_ID      8'hAB
`define SPM_OP_WRITE_EN     8'h06
`define SPM_OP_WRITE_DIS    8'h04
`define SPM_OP_PAGE_PROG    8'h02
`define SPM_OP_SECTOR_ERASE 8'hD8
`define SPM_OP_BULK_ERASE   8'hC7
`define SPM_OP_STATUS_WRITE 8'h01
// Identity byte, arbitrary value
`define SPM_ID_BYTE         8'h5A
// Clock rate in kHz
`define SPM_CLK_KHZ         10000
// Delays in ns, from printed or chosen values
`define SPM_T_DP_NS         3000
`define SPM_T_RES1_NS       3000
`define SPM_T_RES2_NS       1800
`define SPM_T_PUW_NS        1000000
// Cycle counts, least times rounded up
`define SPM_CYC(ns) (((ns) * (`SPM_CLK_KHZ / 1000) + 999) / 1000)
// Mode codes
`define SPM_MODE_STANDBY    2'h0
`define SPM_MODE_ACTIVE     2'h1
`define SPM_MODE_DEEP       2'h2
`define SPM_MODE_WAKING     2'h3
`endif

//--- rtl/spm_timer.v
// Down-counting delay timer used for each power-mode wait.
// Assumes one clock, synchronous reset; load wins over counting.
`timescale 1ns/1ns
module spm_timer #(
    parameter WIDTH = 24
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             sys_rst,
    // Control
    input  wire             load,
    input  wire [WIDTH-1:0] count,
    // Status
    output wire             busy,
    output reg              done
);
    reg [WIDTH-1:0] cnt_r;  // Remaining cycles

    // Count down; done pulses in the cycle the count reaches zero
    always @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r <= {WIDTH{1'b0}};
            done  <= 1'b0;
        end else if (load) begin
            cnt_r <= count;
            done  <= 1'b0;
        end else if (cnt_r != {WIDTH{1'b0}}) begin
            cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
            done  <= (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            done  <= 1'b0;
        end
    end

    assign busy = (cnt_r != {WIDTH{1'b0}});
endmodule

//--- rtl/spm_power_ctrl.v
// Power-mode, identity readout and write lockout of a serial flash.
// Assumes SPI pins arrive asynchronously to mclk and are oversampled.
`timescale 1ns/1ns
`include "spm_defines.vh"
module spm_power_ctrl #(
    parameter [7:0] OP_DEEP_SLEEP   = `SPM_OP_DEEP_SLEEP,
    parameter [7:0] OP_WAKE_ID      = `SPM_OP_WAKE_ID,
    parameter [7:0] ID_BYTE         = `SPM_ID_BYTE,
    parameter       DP_CYC          = `SPM_CYC(`SPM_T_DP_NS),
    parameter       RES1_CYC        = `SPM_CYC(`SPM_T_RES1_NS),
    parameter       RES2_CYC        = `SPM_CYC(`SPM_T_RES2_NS),
    parameter       PUW_CYC         = `SPM_CYC(`SPM_T_PUW_NS)
) (
    // Clock and power-on reset
    input  wire       mclk,
    input  wire       sys_rst,
    // SPI pins from the host
    input  wire       spi_cs_n,
    input  wire       spi_sck,
    input  wire       spi_mosi,
    // SPI data out, three-state
    output reg        spi_miso,
    output reg        spi_miso_oe,
    // Internal write cycle status from the array engine
    input  wire       cycle_busy,
    // Write command qualification from the decoder
    input  wire       write_cmd_seen,
    output wire       write_cmd_allow,
    // Write enable latch control from the decoder
    input  wire       wel_set,
    input  wire       wel_clear,
    // Status
    output reg        write_in_progress_flag,
    output reg        write_enable_latch_flag,
    output reg  [1:0] power_mode,
    output reg        deep_sleep_active
);
    localparam TW = 24;
    // Decoder states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_OP    = 3'h1;
    localparam [2:0] ST_DUMMY = 3'h2;
    localparam [2:0] ST_ID    = 3'h3;
    localparam [2:0] ST_DS8   = 3'h4;
    localparam [2:0] ST_SKIP  = 3'h5;

    // Synchronisers: first stage read only by the second
    reg [1:0] cs_s_r;
    reg [1:0] sck_s_r;
    reg [1:0] mosi_s_r;
    reg       cs_d_r;                 // Delayed select for edges
    reg       sck_d_r;                // Delayed clock for edges

    reg [2:0] state_r;                // Decoder state
    reg [7:0] shift_r;                // Incoming bits
    reg [4:0] bitcnt_r;               // Bits in current phase
    reg [1:0] dumcnt_r;               // Dummy bytes counted
    reg [7:0] id_sh_r;                // Outgoing identity
    reg       id_full_r;              // One full identity sent
    reg       lockout_r;              // Write lockout active
    reg       deep_pend_r;            // Entry delay running
    reg       wake_pend_r;            // Release delay running

    // Timer controls
    reg           tmr_load;
    reg  [TW-1:0] tmr_count;
    wire          tmr_busy;
    wire          tmr_done;
    reg           puw_load_r;
    wire          puw_busy;
    wire          puw_done;

    // Edge strobes, all from synchronised copies
    wire cs_n      = cs_s_r[1];
    wire sck       = sck_s_r[1];
    wire mosi      = mosi_s_r[1];
    wire cs_fall   = cs_d_r & ~cs_n;
    wire cs_rise   = ~cs_d_r & cs_n;
    wire sck_rise  = ~sck_d_r & sck & ~cs_n;
    wire sck_fall  = sck_d_r & ~sck & ~cs_n;
    wire [7:0] byte_in = {shift_r[6:0], mosi};

    // Busy flag mirrors the array engine's self-timed cycle
    wire busy = cycle_busy;

    // Sample pins through two flops
    always @(posedge mclk) begin
        if (sys_rst) begin
            cs_s_r   <= 2'h3;
            sck_s_r  <= 2'h0;
            mosi_s_r <= 2'h0;
            cs_d_r   <= 1'b1;
            sck_d_r  <= 1'b0;
        end else begin
            cs_s_r   <= {cs_s_r[0], spi_cs_n};
            sck_s_r  <= {sck_s_r[0], spi_sck};
            mosi_s_r <= {mosi_s_r[0], spi_mosi};
            cs_d_r   <= cs_n;
            sck_d_r  <= sck;
        end
    end

    // Busy flag, one cycle registered
    always @(posedge mclk) begin
        if (sys_rst)
            write_in_progress_flag <= 1'b0;
        else
            write_in_progress_flag <= busy;
    end

    // Write enable latch; set beats clear, blocked in sleep or lockout
    always @(posedge mclk) begin
        if (sys_rst)
            write_enable_latch_flag <= 1'b0;
        else if (wel_set && write_cmd_allow)
            write_enable_latch_flag <= 1'b1;
        else if (wel_clear)
            write_enable_latch_flag <= 1'b0;
    end

    // Write lockout timer, loaded once after reset release
    always @(posedge mclk) begin
        if (sys_rst) begin
            puw_load_r <= 1'b1;
            lockout_r  <= 1'b1;
        end else begin
            puw_load_r <= 1'b0;
            if (puw_done)
                lockout_r <= 1'b0;
        end
    end

    // Write commands pass only when awake and lockout is over
    assign write_cmd_allow = write_cmd_seen & ~lockout_r &
                             (power_mode != `SPM_MODE_DEEP) &
                             (power_mode != `SPM_MODE_WAKING);

    // Serial decoder and power-mode sequencing
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_r           <= ST_IDLE;
            shift_r           <= 8'h00;
            bitcnt_r          <= 5'h00;
            dumcnt_r          <= 2'h0;
            id_sh_r           <= 8'h00;
            id_full_r         <= 1'b0;
            spi_miso          <= 1'b0;
            spi_miso_oe       <= 1'b0;
            power_mode        <= `SPM_MODE_STANDBY;
            deep_sleep_active <= 1'b0;
            deep_pend_r       <= 1'b0;
            wake_pend_r       <= 1'b0;
            tmr_load          <= 1'b0;
            tmr_count         <= {TW{1'b0}};
        end else begin
            tmr_load <= 1'b0;
            // Timer completions
            if (tmr_done && deep_pend_r) begin
                deep_pend_r       <= 1'b0;
                power_mode        <= `SPM_MODE_DEEP;
                deep_sleep_active <= 1'b1;
            end
            if (tmr_done && wake_pend_r) begin
                wake_pend_r <= 1'b0;
                power_mode  <= `SPM_MODE_STANDBY;
            end
            // Selection starts a fresh instruction
            if (cs_fall) begin
                state_r   <= ST_OP;
                bitcnt_r  <= 5'h00;
                id_full_r <= 1'b0;
                if (power_mode == `SPM_MODE_STANDBY)
                    power_mode <= `SPM_MODE_ACTIVE;
            end else if (cs_n) begin
                spi_miso_oe <= 1'b0;
            end
            // Bit capture on rising serial clock
            if (sck_rise) begin
                shift_r <= byte_in;
                case (state_r)
                    ST_OP: begin
                        if (bitcnt_r == 5'd7) begin
                            bitcnt_r <= 5'h00;
                            // Not decoded while busy; sleep ignores others
                            if (byte_in == OP_WAKE_ID && !busy) begin
                                state_r  <= ST_DUMMY;
                                dumcnt_r <= 2'h0;
                            end else if (byte_in == OP_DEEP_SLEEP &&
                                         !busy && !deep_sleep_active &&
                                         !wake_pend_r)
                                state_r <= ST_DS8;
                            else
                                state_r <= ST_SKIP;
                        end else begin
                            bitcnt_r <= bitcnt_r + 5'h01;
                        end
                    end
                    ST_DUMMY: begin
                        if (bitcnt_r == 5'd7) begin
                            bitcnt_r <= 5'h00;
                            dumcnt_r <= dumcnt_r + 2'h1;
                            if (dumcnt_r == 2'h2) begin
                                state_r <= ST_ID;
                                id_sh_r <= ID_BYTE;
                            end
                        end else begin
                            bitcnt_r <= bitcnt_r + 5'h01;
                        end
                    end
                    ST_ID: begin
                        if (bitcnt_r == 5'd7) begin
                            bitcnt_r  <= 5'h00;
                            id_full_r <= 1'b1;
                            id_sh_r   <= ID_BYTE;
                        end else begin
                            bitcnt_r <= bitcnt_r + 5'h01;
                        end
                    end
                    ST_DS8:
                        state_r <= ST_SKIP;   // Ninth bit cancels
                    default: ;
                endcase
            end
            // Identity bits leave on the falling serial clock, MSB first
            if (sck_fall && state_r == ST_ID) begin
                spi_miso    <= id_sh_r[7];
                spi_miso_oe <= 1'b1;
                id_sh_r     <= {id_sh_r[6:0], id_sh_r[7]};
            end
            // Deselect ends the instruction
            if (cs_rise) begin
                state_r <= ST_IDLE;
                if (state_r == ST_DS8 && !busy) begin
                    deep_pend_r <= 1'b1;
                    tmr_load    <= 1'b1;
                    tmr_count   <= DP_CYC[TW-1:0];
                    power_mode  <= `SPM_MODE_STANDBY;
                end else if ((state_r == ST_DUMMY || state_r == ST_ID) &&
                             deep_sleep_active) begin
                    // Leave deep sleep; delay depends on read length
                    deep_sleep_active <= 1'b0;
                    wake_pend_r       <= 1'b1;
                    power_mode        <= `SPM_MODE_WAKING;
                    tmr_load          <= 1'b1;
                    tmr_count         <= id_full_r ?
                                         RES2_CYC[TW-1:0] :
                                         RES1_CYC[TW-1:0];
                end else if (!deep_sleep_active && !wake_pend_r &&
                             !deep_pend_r) begin
                    // Standby at once; busy keeps the part active
                    power_mode <= busy ? `SPM_MODE_ACTIVE :
                                         `SPM_MODE_STANDBY;
                end else if (deep_sleep_active) begin
                    power_mode <= `SPM_MODE_DEEP;
                end
            end
            // Busy cycle ending returns a deselected part to standby
            if (cs_n && !cs_rise && !busy &&
                power_mode == `SPM_MODE_ACTIVE)
                power_mode <= `SPM_MODE_STANDBY;
        end
    end

    // Shared timer for entry and release delays
    spm_timer #(.WIDTH(TW)) u_mode_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .load    (tmr_load),
        .count   (tmr_count),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // Lockout timer after power-on release
    spm_timer #(.WIDTH(TW)) u_puw_tmr (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .load    (puw_load_r),
        .count   (PUW_CYC[TW-1:0]),
        .busy    (puw_busy),
        .done    (puw_done)
    );
endmodule

//--- testbench/spm_power_ctrl_chk.sv
// Port-level checker for the flash power-mode block.
// Assumes one mclk domain; bound to every spm_power_ctrl instance.
`timescale 1ns/1ns
module spm_power_chk #(
    parameter DP_CYC  = 30,
    parameter PUW_CYC = 10000
) (
    // Clock and reset
    input wire       mclk,
    input wire       sys_rst,
    // SPI select and data-out enable
    input wire       spi_cs_n,
    input wire       spi_miso_oe,
    // Array and decoder side
    input wire       cycle_busy,
    input wire       write_cmd_seen,
    input wire       write_cmd_allow,
    input wire       wel_set,
    // Status
    input wire       write_in_progress_flag,
    input wire       write_enable_latch_flag,
    input wire [1:0] power_mode,
    input wire       deep_sleep_active
);
    reg [15:0] spm_up_r; // Cycles since reset release, saturating
    reg [7:0]  spm_hi_r; // Cycles with select high, saturating
    // Helper counters; saturate so long idle spans never wrap
    always @(posedge mclk) begin
        if (sys_rst || !spi_cs_n) spm_hi_r <= 8'h00;
        else if (spm_hi_r != 8'hFF) spm_hi_r <= spm_hi_r + 8'h01;
        if (sys_rst) spm_up_r <= 16'h0000;
        else if (spm_up_r != 16'hFFFF) spm_up_r <= spm_up_r + 16'h0001;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    rst_state_a:
        assert property ($fell(sys_rst) |-> power_mode == 2'h0 &&
            !deep_sleep_active && !write_enable_latch_flag && !spi_miso_oe)
        else $error("state after reset wrong");
    lock_hold_a:
        assert property (spm_up_r < PUW_CYC |-> !write_cmd_allow)
        else $error("write allowed during lockout");
    allow_gate_a:
        assert property (write_cmd_allow |-> write_cmd_seen && !power_mode[1])
        else $error("write allowed while asleep or unseen");
    wel_set_a:
        assert property (wel_set && write_cmd_allow |=> write_enable_latch_flag)
        else $error("latch flag not set");
    deep_wait_a:
        assert property ($rose(deep_sleep_active) |-> spm_hi_r >= DP_CYC)
        else $error("deep sleep entered too early");
    deep_stay_a:
        assert property (power_mode == 2'h2 && spm_hi_r >= 8'd8 |=>
            power_mode == 2'h2 && deep_sleep_active)
        else $error("deep sleep left while deselected");
    wake_hold_a:
        assert property ($rose(power_mode == 2'h3) |->
            (power_mode == 2'h3) [*8] ##[1:40] power_mode == 2'h0)
        else $error("release delay wrong");
    oe_idle_a:
        assert property (spm_hi_r >= 8'd5 |-> !spi_miso_oe)
        else $error("data out driven while deselected");
    busy_mute_a:
        assert property (cycle_busy [*8] |-> !spi_miso_oe && power_mode != 2'h2)
        else $error("command acted on while busy");
    wip_track_a:
        assert property (cycle_busy [*2] |-> write_in_progress_flag)
        else $error("busy flag missing");
    cover property ($rose(deep_sleep_active));
    cover property ($rose(power_mode == 2'h3));
    cover property ($rose(spi_miso_oe));
endmodule
bind spm_power_ctrl spm_power_chk #(.DP_CYC(DP_CYC), .PUW_CYC(PUW_CYC)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
    .spi_miso_oe(spi_miso_oe), .cycle_busy(cycle_busy),
    .write_cmd_seen(write_cmd_seen), .write_cmd_allow(write_cmd_allow),
    .wel_set(wel_set), .write_in_progress_flag(write_in_progress_flag),
    .write_enable_latch_flag(write_enable_latch_flag),
    .power_mode(power_mode), .deep_sleep_active(deep_sleep_active));

//--- testbench/spm_host_model.sv
// Host controller model: drives select, serial clock and data, mode 0.
// Assumes its task is called just after a rising mclk edge.
`timescale 1ns/1ns
module spm_host_model #(
    parameter HALF = 6
) (
    // Clock
    input wire mclk,
    // SPI pins
    output reg spi_cs_n,
    output reg spi_sck,
    output reg spi_mosi,
    input wire spi_q
);
    // Idle: deselected, clock stands low outside frames
    initial begin
        spi_cs_n = 1'b1;
        spi_sck  = 1'b0;
        spi_mosi = 1'b0;
    end
    // Data toggles while deselected so stale bits never look valid
    always @(posedge mclk) begin
        if (spi_cs_n) spi_mosi <= ~spi_mosi;
    end
    // One frame of n bits, MSB first; returns what came back
    task frame(input [47:0] v, input integer n, output [47:0] r);
        integer i;
        begin
            r = 48'h0;
            spi_cs_n <= 1'b0;
            repeat (HALF) @(posedge mclk);
            for (i = n - 1; i >= 0; i = i - 1) begin
                spi_mosi <= v[i];
                repeat (HALF) @(posedge mclk);
                spi_sck <= 1'b1;
                r[i] = spi_q; // Taken on the rising clock
                repeat (HALF) @(posedge mclk);
                spi_sck <= 1'b0;
            end
            repeat (HALF) @(posedge mclk);
            spi_cs_n <= 1'b1; // Only after the last whole bit
            repeat (2 * HALF) @(posedge mclk);
        end
    endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the flash power-mode block.
// Assumes the host model and bound checker; lockout shortened to 20.
`timescale 1ns/1ns
`include "spm_defines.vh"
module tb_top;
    localparam PUW = 20;
    localparam DPC = 30;
    localparam R1  = 30;
    localparam R2  = 18;
    // Clock, reset and decoder-side stimulus
    reg        mclk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        cycle_busy = 1'b0;
    reg        write_cmd_seen = 1'b0;
    reg        wel_set = 1'b0;
    reg        wel_clear = 1'b0;
    wire       spi_cs_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
    wire       write_cmd_allow, write_in_progress_flag;
    wire       write_enable_latch_flag, deep_sleep_active;
    wire [1:0] power_mode;
    // Undriven data line floats, so a silent device never matches
    wire       spi_q = spi_miso_oe ? spi_miso : 1'bz;
    integer    errors = 0, tests_run = 0, cycles = 0, n, exp_mode;
    reg [47:0] r;
    reg        oe_seen = 1'b0;
    always #50 mclk = ~mclk;
    spm_power_ctrl #(.DP_CYC(DPC), .RES1_CYC(R1), .RES2_CYC(R2),
        .PUW_CYC(PUW)) u_spm_power_ctrl (.mclk(mclk), .sys_rst(sys_rst),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .cycle_busy(cycle_busy), .write_cmd_seen(write_cmd_seen),
        .write_cmd_allow(write_cmd_allow), .wel_set(wel_set),
        .wel_clear(wel_clear), .write_in_progress_flag(write_in_progress_flag),
        .write_enable_latch_flag(write_enable_latch_flag),
        .power_mode(power_mode), .deep_sleep_active(deep_sleep_active));
    spm_host_model host (.mclk(mclk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_q(spi_q));
    // Watch for any drive of the data-out pin
    always @(posedge mclk) if (spi_miso_oe === 1'b1) oe_seen <= 1'b1;
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
            end
        end
    endtask
    // Wait until mode is m (stay 0) or while it is m (stay 1)
    task wait_mode(input [1:0] m, input stay, output integer k);
        begin
            k = 0;
            while (((power_mode === m) == stay) && k < 300) begin
                @(posedge mclk);
                k = k + 1;
            end
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, errors);
            if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Hang guard, well above the expected run of a few thousand cycles
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("BAD %0t run did not finish", $time);
            conclude;
        end
    end
    initial begin
        exp_mode = 0;
        void'($urandom(8));
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        write_cmd_seen <= 1'b1;
        wel_set <= 1'b1;
        @(negedge mclk);
        check(power_mode, exp_mode);
        check(write_cmd_allow, 0);
        @(posedge mclk);
        wel_set <= 1'b0;
        repeat (PUW + 4) @(posedge mclk);
        check(write_enable_latch_flag, 0);
        check(write_cmd_allow, 1);
        wel_set <= 1'b1;
        @(posedge mclk);
        wel_set <= 1'b0;
        wel_clear <= 1'b1;
        @(negedge mclk);
        check(write_enable_latch_flag, 1);
        @(posedge mclk);
        wel_clear <= 1'b0;
        host.frame({`SPM_OP_WAKE_ID, 24'($urandom), 16'h0}, 48, r);
        check(r[15:0], {2{`SPM_ID_BYTE}});
        check(power_mode, exp_mode);
        host.frame({40'h0, `SPM_OP_DEEP_SLEEP}, 8, r);
        wait_mode(2'h2, 1'b0, n);
        check(n + 12 >= DPC && n + 12 <= DPC + 8, 1);
        host.frame({40'h0, `SPM_OP_WRITE_EN}, 8, r);
        check(deep_sleep_active, 1);
        check(write_cmd_allow, 0);
        host.frame({40'h0, `SPM_OP_WAKE_ID}, 8, r);
        wait_mode(2'h3, 1'b1, n);
        check(n >= R1 - 14 && n <= R1 - 4, 1);
        host.frame({40'h0, `SPM_OP_DEEP_SLEEP}, 8, r);
        wait_mode(2'h2, 1'b0, n);
        host.frame({`SPM_OP_WAKE_ID, 24'($urandom), 16'h0}, 48, r);
        check(r[15:0], {2{`SPM_ID_BYTE}});
        wait_mode(2'h3, 1'b1, n);
        check(n >= R2 - 14 && n <= R2 - 4, 1);
        host.frame({39'h0, `SPM_OP_DEEP_SLEEP, 1'b1}, 9, r);
        repeat (60) @(posedge mclk);
        check(power_mode, exp_mode);
        cycle_busy <= 1'b1;
        oe_seen <= 1'b0;
        host.frame({40'h0, `SPM_OP_DEEP_SLEEP}, 8, r);
        host.frame({`SPM_OP_WAKE_ID, 24'($urandom), 16'h0}, 48, r);
        repeat (60) @(posedge mclk);
        check(power_mode, `SPM_MODE_ACTIVE);
        check(oe_seen, 0);
        check(write_in_progress_flag, 1);
        cycle_busy <= 1'b0;
        repeat (3) @(posedge mclk);
        check(write_in_progress_flag, 0);
        check(power_mode, `SPM_MODE_STANDBY);
        host.frame({40'h0, `SPM_OP_DEEP_SLEEP}, 8, r);
        wait_mode(2'h2, 1'b0, n);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        check({deep_sleep_active, power_mode}, 0);
        conclude;
    end
endmodule
